// file: design/asc_consts.svh
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ASC_OFS_CTL_ONE       8'h00
`define ASC_OFS_CTL_TWO       8'h04
`define ASC_OFS_INT_STATUS    8'h08
`define ASC_OFS_INT_MASK      8'h0C

// ----------------------------------------------------------------
// writable bits and reset values
// ----------------------------------------------------------------
`define ASC_CTL_ONE_WMASK     16'hA7EC
`define ASC_CTL_TWO_WMASK     16'hE73F
`define ASC_CTL_ONE_RESET     16'h0000
`define ASC_CTL_TWO_RESET     16'h0000

// ----------------------------------------------------------------
// field positions, converter_control_one
// ----------------------------------------------------------------
`define ASC_C1_MODULE_ON      15
`define ASC_C1_TWELVE_BIT     10
`define ASC_C1_TRIG_LSB       5
`define ASC_C1_SIMUL          3
`define ASC_C1_AUTO_SAMPLE    2
`define ASC_C1_SAMPLE_ACTIVE  1
`define ASC_C1_DONE           0

// ----------------------------------------------------------------
// field positions, converter_control_two and interrupt bits
// ----------------------------------------------------------------
`define ASC_C2_CHAN_LSB       8
`define ASC_INT_CONV_DONE     0
`define ASC_INT_SAMPLE_END    1

// ----------------------------------------------------------------
// trigger source codes
// ----------------------------------------------------------------
`define ASC_TRIG_MANUAL       3'h0
`define ASC_TRIG_PIN          3'h1
`define ASC_TRIG_TIMER        3'h2
`define ASC_TRIG_PWM          3'h3
`define ASC_TRIG_COUNTER      3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ASC_CLK_NS            10
`define ASC_AUTO_SAMPLE_NS    310
`define ASC_AUTO_SAMPLE_CYC   \
   ((`ASC_AUTO_SAMPLE_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)

`endif

// file: design/asc_pkg.sv
package asc_pkg;

   typedef enum logic [1:0] {
      ASC_IDLE,
      ASC_SAMPLE,
      ASC_CONVERT
   } asc_state_e;

   typedef struct packed {
      logic [2:0] stage;
      logic       level;
      logic       rise;
   } asc_sync_s;

   typedef struct packed {
      asc_state_e  state;
      logic [15:0] ctl_one;
      logic [15:0] ctl_two;
      logic        done;
      logic [1:0]  int_status;
      logic [1:0]  int_mask;
      logic [7:0]  sample_active_flag_cnt;
      logic [1:0]  ch_idx;
      logic [1:0]  ch_last;
      logic        simul;
      logic [3:0]  sh_sample;
      logic        conv_start;
      logic [1:0]  conv_channel;
      logic        irq;
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
      logic        wr_pend;
      logic [7:0]  wr_addr;
   } asc_state_s;

endpackage

// file: design/asc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module asc_pin_sync
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic pin,
   output logic      level,
   output logic      rise
);

   asc_pkg::asc_sync_s r_reg;
   asc_pkg::asc_sync_s r_next;

   // ----------------------------------------------------------------
   // three stages; a change counts once stages two and three agree
   // ----------------------------------------------------------------
   always_comb
   begin
      r_next       = r_reg;
      r_next.stage = {r_reg.stage[1:0], pin};
      r_next.rise  = 1'b0;
      if (r_reg.stage[1] == r_reg.stage[2])
      begin
         r_next.level = r_reg.stage[2];
         r_next.rise  = r_reg.stage[2] & ~r_reg.level;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end

   assign level = r_reg.level;
   assign rise  = r_reg.rise;

endmodule // asc_pin_sync

`default_nettype wire

// file: design/asc_sample_control.sv
`include "asc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module asc_sample_control
#(
   parameter int AUTO_SAMPLE_CYC = `ASC_AUTO_SAMPLE_CYC
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        trig_pin,
   input  wire logic        timer_trigger,
   input  wire logic        pwm_trigger,
   input  wire logic        conv_done,
   output logic [3:0]       sh_sample,
   output logic             conv_start,
   output logic [1:0]       conv_channel,
   output logic             irq
);

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   if (AUTO_SAMPLE_CYC < 1 || AUTO_SAMPLE_CYC > 255)
   begin : g_bad_param
      $error("AUTO_SAMPLE_CYC must lie in 1..255");
   end

   localparam logic [7:0] SAMPLE_ACTIVE_FLAG_LAST = 8'(AUTO_SAMPLE_CYC - 1);

   asc_pkg::asc_state_s r_reg;
   asc_pkg::asc_state_s r_next;

   logic pin_rise;
   logic wr_one;
   logic trig_fire;
   logic sw_start;
   logic sw_end;
   logic finish;

   asc_pin_sync u_pin_sync
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin     (trig_pin),
      .level   (),
      .rise    (pin_rise)
   );

   // ----------------------------------------------------------------
   // write strobes and trigger selection
   // ----------------------------------------------------------------
   assign wr_one = r_reg.wr_pend && (r_reg.wr_addr == `ASC_OFS_CTL_ONE);

   always_comb
   begin
      unique case (r_reg.ctl_one[`ASC_C1_TRIG_LSB +: 3])
         `ASC_TRIG_PIN:     trig_fire = pin_rise;
         `ASC_TRIG_TIMER:   trig_fire = timer_trigger;
         `ASC_TRIG_PWM:     trig_fire = pwm_trigger;
         `ASC_TRIG_COUNTER: trig_fire = (r_reg.sample_active_flag_cnt == SAMPLE_ACTIVE_FLAG_LAST);
         default:           trig_fire = 1'b0;
      endcase
   end

   assign sw_start = wr_one && hwdata[`ASC_C1_SAMPLE_ACTIVE];
   assign sw_end   = wr_one && !hwdata[`ASC_C1_SAMPLE_ACTIVE];
   assign finish   = (r_reg.state == asc_pkg::ASC_CONVERT) && conv_done
                     && (r_reg.ch_idx == r_reg.ch_last);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic       on;
      logic       auto_sample_start;
      logic [2:0] trig;
      logic [1:0] last;
      logic       ev_done;
      logic       ev_end;
      on      = 1'b0;
      auto_sample_start    = 1'b0;
      trig    = 3'h0;
      last    = 2'h0;
      ev_done = 1'b0;
      ev_end  = 1'b0;
      r_next  = r_reg;
      r_next.conv_start = 1'b0;

      // bus write data phase; mode changes take effect at once, except the trigger source, which takes effect a cycle later
      if (wr_one)
      begin
         r_next.ctl_one = hwdata[15:0] & `ASC_CTL_ONE_WMASK;
         if (!hwdata[`ASC_C1_DONE])
            r_next.done = 1'b0;
      end
      if (r_reg.wr_pend && r_reg.wr_addr == `ASC_OFS_CTL_TWO)
         r_next.ctl_two = hwdata[15:0] & `ASC_CTL_TWO_WMASK;
      if (r_reg.wr_pend && r_reg.wr_addr == `ASC_OFS_INT_MASK)
         r_next.int_mask = hwdata[1:0];

      on   = r_next.ctl_one[`ASC_C1_MODULE_ON];
      auto_sample_start = r_next.ctl_one[`ASC_C1_AUTO_SAMPLE];
      trig = r_reg.ctl_one[`ASC_C1_TRIG_LSB +: 3];
      if (r_next.ctl_one[`ASC_C1_TWELVE_BIT])
         last = 2'h0;
      else if (r_next.ctl_two[`ASC_C2_CHAN_LSB +: 2] == 2'h0)
         last = 2'h0;
      else if (r_next.ctl_two[`ASC_C2_CHAN_LSB +: 2] == 2'h1)
         last = 2'h1;
      else
         last = 2'h3;

      unique case (r_reg.state)
         asc_pkg::ASC_IDLE:
         begin
            if (on && (auto_sample_start || sw_start))
            begin
               r_next.state     = asc_pkg::ASC_SAMPLE;
               r_next.sample_active_flag_cnt  = 8'h00;
               r_next.ch_last   = last;
               r_next.sh_sample = 4'((5'h2 << last) - 5'h1);
            end
         end
         asc_pkg::ASC_SAMPLE:
         begin
            r_next.sample_active_flag_cnt = r_reg.sample_active_flag_cnt + 8'h01;
            if (!on)
            begin
               r_next.state     = asc_pkg::ASC_IDLE;
               r_next.sh_sample = 4'h0;
            end
            else if ((trig == `ASC_TRIG_MANUAL && sw_end)
                     || (trig != `ASC_TRIG_MANUAL && trig_fire))
            begin
               ev_end              = 1'b1;
               r_next.state        = asc_pkg::ASC_CONVERT;
               r_next.done         = 1'b0;
               r_next.conv_start   = 1'b1;
               r_next.conv_channel = 2'h0;
               r_next.ch_idx       = 2'h0;
               r_next.simul        = r_next.ctl_one[`ASC_C1_SIMUL]
                                     && (r_reg.ch_last != 2'h0);
               // all channels freeze together, or only the first one
               if (r_next.simul)
                  r_next.sh_sample = 4'h0;
               else
                  r_next.sh_sample = r_reg.sh_sample & 4'hE;
            end
         end
         asc_pkg::ASC_CONVERT:
         begin
            // a done clear from software leaves this sequence alone
            if (finish)
            begin
               ev_done     = 1'b1;
               r_next.done = 1'b1;
               if (on && auto_sample_start)
               begin
                  r_next.state     = asc_pkg::ASC_SAMPLE;
                  r_next.sample_active_flag_cnt  = 8'h00;
                  r_next.ch_last   = last;
                  r_next.sh_sample = 4'((5'h2 << last) - 5'h1);
               end
               else
               begin
                  r_next.state     = asc_pkg::ASC_IDLE;
                  r_next.sh_sample = 4'h0;
               end
            end
            else if (conv_done)
            begin
               r_next.ch_idx       = r_reg.ch_idx + 2'h1;
               r_next.conv_channel = r_reg.ch_idx + 2'h1;
               r_next.conv_start   = 1'b1;
               r_next.sh_sample    = r_reg.sh_sample
                                     & ~(4'h2 << r_reg.ch_idx);
            end
         end
      endcase

      r_next.int_status = r_next.int_status
                          | {ev_end, ev_done};

      // ----------------------------------------------------------------
      // bus address phase; single cycle answers, no wait states
      // ----------------------------------------------------------------
      r_next.wr_pend = 1'b0;
      r_next.hrdata  = 32'h0000_0000;
      if (hsel && hready && htrans[1])
      begin
         r_next.wr_pend = hwrite;
         r_next.wr_addr = haddr[7:0];
         if (!hwrite)
         begin
            unique case (haddr[7:0])
               `ASC_OFS_CTL_ONE:
                  r_next.hrdata = {16'h0000, r_next.ctl_one[15:2],
                     r_next.state == asc_pkg::ASC_SAMPLE,
                     r_next.done};
               `ASC_OFS_CTL_TWO:
                  r_next.hrdata = {16'h0000, r_next.ctl_two[15:10],
                     r_next.ctl_one[`ASC_C1_TWELVE_BIT]
                        ? 2'h0 : r_next.ctl_two[9:8],
                     r_next.ctl_two[7:0]};
               `ASC_OFS_INT_STATUS:
               begin
                  r_next.hrdata     = {30'h0, r_next.int_status};
                  // cleared only after it was returned, so no event is lost
                  r_next.int_status = 2'h0;
               end
               `ASC_OFS_INT_MASK:
                  r_next.hrdata = {30'h0, r_next.int_mask};
               default:
                  r_next.hrdata = 32'h0000_0000;
            endcase
         end
      end
      r_next.irq       = |(r_next.int_status & r_next.int_mask);
      r_next.hreadyout = 1'b1;
      r_next.hresp     = 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         r_reg           <= '0;
         r_reg.state     <= asc_pkg::ASC_IDLE;
         r_reg.ctl_one   <= `ASC_CTL_ONE_RESET;
         r_reg.ctl_two   <= `ASC_CTL_TWO_RESET;
         r_reg.hreadyout <= 1'b1;
      end
      else
         r_reg <= r_next;
   end

   assign hrdata       = r_reg.hrdata;
   assign hreadyout    = r_reg.hreadyout;
   assign hresp        = r_reg.hresp;
   assign sh_sample    = r_reg.sh_sample;
   assign conv_start   = r_reg.conv_start;
   assign conv_channel = r_reg.conv_channel;
   assign irq          = r_reg.irq;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_sample_reads_state: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (r_reg.state == asc_pkg::ASC_SAMPLE) |-> r_reg.sh_sample[0])
      else $error("channel zero not acquiring in sample phase");

   a_sw_start_sample: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (sw_start && r_reg.state == asc_pkg::ASC_IDLE
       && hwdata[`ASC_C1_MODULE_ON])
      |=> (r_reg.state == asc_pkg::ASC_SAMPLE))
      else $error("software start did not begin sampling");

   a_auto_start_idle: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (wr_one && r_reg.state == asc_pkg::ASC_IDLE
       && hwdata[`ASC_C1_AUTO_SAMPLE]
       && hwdata[`ASC_C1_MODULE_ON])
      |=> (r_reg.state == asc_pkg::ASC_SAMPLE))
      else $error("auto start did not begin sampling");

   a_manual_end_conv: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (sw_end && hwdata[`ASC_C1_MODULE_ON]
       && r_reg.state == asc_pkg::ASC_SAMPLE
       && r_reg.ctl_one[`ASC_C1_TRIG_LSB +: 3] == `ASC_TRIG_MANUAL)
      |=> (r_reg.state == asc_pkg::ASC_CONVERT) && r_reg.conv_start)
      else $error("manual end did not start conversion");

   a_trigger_end_conv: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (!wr_one && trig_fire && r_reg.state == asc_pkg::ASC_SAMPLE
       && r_reg.ctl_one[`ASC_C1_TRIG_LSB +: 3] != `ASC_TRIG_MANUAL)
      |=> (r_reg.state == asc_pkg::ASC_CONVERT) ##1 !r_reg.conv_start)
      else $error("trigger did not end sampling exactly once");

   a_done_on_finish: assert property (@(posedge hclk)
      disable iff (!hresetn)
      finish |=> r_reg.done
                 && (r_reg.int_status[`ASC_INT_CONV_DONE] || r_reg.hrdata[0]))
      else $error("done not set when conversion finished");

   a_done_no_sw_set: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (wr_one && !r_reg.done && !finish) |=> !r_reg.done)
      else $error("software write set the done flag");

   a_clear_keeps_conv: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (wr_one && hwdata[`ASC_C1_MODULE_ON] && !conv_done
       && r_reg.state == asc_pkg::ASC_CONVERT)
      |=> (r_reg.state == asc_pkg::ASC_CONVERT)
          && $stable(r_reg.conv_channel))
      else $error("done clear disturbed the conversion");

   a_start_clears_done: assert property (@(posedge hclk)
      disable iff (!hresetn)
      r_reg.conv_start |-> !r_reg.done)
      else $error("done still set while a conversion starts");

   a_simul_hold_all: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (r_reg.conv_start && r_reg.simul) |-> (r_reg.sh_sample == 4'h0))
      else $error("simultaneous mode left a channel acquiring");

   a_auto_restart: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (finish && r_reg.ctl_one[`ASC_C1_AUTO_SAMPLE] && !wr_one
       && r_reg.ctl_one[`ASC_C1_MODULE_ON])
      |=> (r_reg.state == asc_pkg::ASC_SAMPLE) && (r_reg.sample_active_flag_cnt == 8'h00))
      else $error("sampling did not restart after conversion");

   a_irq_follows: assert property (@(posedge hclk)
      disable iff (!hresetn)
      irq == |(r_reg.int_status & r_reg.int_mask))
      else $error("interrupt output disagrees with status and mask");

endmodule // asc_sample_control

`default_nettype wire

// file: bench/asc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// converter core stand-in: one conv_done per conv_start, lat cycles on
// ----------------------------------------------------------------
module asc_conv_model
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       conv_start,
   input  wire logic [7:0] lat,
   output logic            conv_done,
   output logic [7:0]      starts
);
   logic       busy;
   logic [7:0] cnt;

   // lat is sampled at start, so the bench may switch prompt/slow between runs
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         busy      <= 1'b0;
         cnt       <= 8'h00;
         conv_done <= 1'b0;
         starts    <= 8'h00;
      end
      else
      begin
         conv_done <= 1'b0;
         if (conv_start)
         begin
            busy   <= 1'b1;
            cnt    <= lat;
            starts <= starts + 8'h01;
         end
         else if (busy)
         begin
            if (cnt <= 8'h01)
            begin
               conv_done <= 1'b1;
               busy      <= 1'b0;
            end
            else
               cnt <= cnt - 8'h01;
         end
      end
   end
endmodule // asc_conv_model

`default_nettype wire

// file: bench/test_adc_sample_convert_control.sv
`include "asc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module test_adc_sample_convert_control;
   localparam int   ACYC = 4;
   localparam logic [7:0] C1 = `ASC_OFS_CTL_ONE;
   localparam logic [7:0] C2 = `ASC_OFS_CTL_TWO;
   localparam logic [7:0] ST = `ASC_OFS_INT_STATUS;
   localparam logic [7:0] MK = `ASC_OFS_INT_MASK;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic        trig_pin, timer_trigger, pwm_trigger, conv_start, conv_done;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, conv_channel;
   logic [2:0]  hsize, code;
   logic [3:0]  sh_sample;
   logic [7:0]  lat, starts, s0;
   int          err_count, checked, n;

   asc_sample_control #(.AUTO_SAMPLE_CYC(ACYC)) DUT (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .trig_pin(trig_pin), .timer_trigger(timer_trigger),
      .pwm_trigger(pwm_trigger), .conv_done(conv_done),
      .sh_sample(sh_sample), .conv_start(conv_start),
      .conv_channel(conv_channel), .irq(irq));
   asc_conv_model MODEL (.hclk(hclk), .hresetn(hresetn),
      .conv_start(conv_start), .lat(lat),
      .conv_done(conv_done), .starts(starts));

   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // ----------------------------------------------------------------
   // reporting
   // ----------------------------------------------------------------
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask

   // ----------------------------------------------------------------
   // bus access; every wait is bounded
   // ----------------------------------------------------------------
   task automatic wait_ready(output logic [31:0] d);
      int   k;
      logic r;
      k = 0;
      r = 1'b0;
      d = 32'h00000000;
      do
      begin
         // look between edges: what stands before the rising edge is taken
         @(negedge hclk);
         r = hreadyout;
         d = hrdata;
         @(posedge hclk);
         k++;
      end
      while (r !== 1'b1 && k < 20);
      if (r !== 1'b1)
      begin
         err_count++;
         give_verdict();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] data);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h000000, a};
      wait_ready(data);
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready(data);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      bus(1'b1, a, d, unused);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
      bus(1'b0, a, 32'h00000000, rd);
      chk(rd, exp, what);
   endtask

   // polls until the conversion sequence reports done
   task automatic wait_done;
      int k;
      k = 0;
      do
      begin
         bus(1'b0, C1, 32'h00000000, rd);
         k++;
      end
      while (rd[0] !== 1'b1 && k < 100);
      if (rd[0] !== 1'b1)
      begin
         err_count++;
         give_verdict();
      end
   endtask

   task automatic manual_run;
      wr(C1, 32'h00008002);
      wr(C1, 32'h00008000);
      wait_done();
   endtask

   task automatic pulse(input logic [2:0] c);
      trig_pin      <= (c == 3'h1);
      timer_trigger <= (c == 3'h2);
      pwm_trigger   <= (c == 3'h3);
      @(posedge hclk);
      timer_trigger <= 1'b0;
      pwm_trigger   <= 1'b0;
      repeat (4) @(posedge hclk);
      trig_pin      <= 1'b0;
      @(posedge hclk);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      trig_pin = 1'b0;
      timer_trigger = 1'b0;
      pwm_trigger = 1'b0;
      lat = 8'h06;
      err_count = 0;
      checked = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk(C1, 32'h00000000, "control one reset");
      rdchk(C2, 32'h00000000, "control two reset");
      wr(8'h10, 32'h0000FFFF);
      rdchk(8'h10, 32'h00000000, "unmapped");
      chk({31'h0, hresp}, 32'h0, "okay response");
      wr(C1, 32'h00008000);
      wr(C1, 32'h00008002);
      @(posedge hclk);
      chk({28'h0, sh_sample}, 32'h1, "acquiring");
      rdchk(C1, 32'h00008002, "sampling flag");
      wr(C1, 32'h00008000);
      rdchk(C1, 32'h00008000, "converting");
      wr(C1, 32'h00008000);
      wait_done();
      chk(rd, 32'h00008001, "done set");
      wr(C1, 32'h00008003);
      rdchk(C1, 32'h00008003, "done kept while sampling");
      wr(C1, 32'h00008001);
      rdchk(C1, 32'h00008000, "done cleared at new conversion");
      wait_done();
      wr(C1, 32'h00008003);
      wr(C1, 32'h00008002);
      rdchk(C1, 32'h00008002, "clear leaves sampling");
      chk({28'h0, sh_sample}, 32'h1, "still acquiring");
      wr(C1, 32'h00008003);
      rdchk(C1, 32'h00008002, "write one refused");
      wr(C1, 32'h00008000);
      wait_done();
      // interrupts: both events pending now, unmask, clear on read, remask
      wr(MK, 32'h00000001);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h1, "irq unmasked");
      rdchk(ST, 32'h00000003, "status");
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0, "irq after read");
      wr(MK, 32'h00000000);
      manual_run();
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr(MK, 32'h00000002);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h1, "irq sample end");
      rdchk(ST, 32'h00000003, "status again");
      // trigger sources, the internal counter last
      for (n = 0; n < 4; n++)
      begin
         code = (n == 3) ? 3'h7 : 3'(n + 1);
         wr(C1, 32'h00008002 | ({29'h0, code} << 5));
         if (code != 3'h7)
         begin
            repeat (8) @(posedge hclk);
            rdchk(C1, 32'h00008002 | ({29'h0, code} << 5), "waits");
            pulse(code);
         end
         wait_done();
         chk(rd, 32'h00008001 | ({29'h0, code} << 5), "trigger end");
      end
      wr(C1, 32'h00008082);
      pulse(3'h1);
      pulse(3'h2);
      pulse(3'h3);
      rdchk(C1, 32'h00008082, "reserved code");
      wr(C1, 32'h00000000);
      // four channels, together then one at a time
      wr(C2, 32'h00000200);
      rdchk(C2, 32'h00000200, "channel select");
      wr(C1, 32'h00008008);
      wr(C1, 32'h0000800A);
      @(posedge hclk);
      chk({28'h0, sh_sample}, 32'hF, "all acquire");
      s0 = starts;
      wr(C1, 32'h00008008);
      repeat (2) @(posedge hclk);
      chk({28'h0, sh_sample}, 32'h0, "all hold at once");
      wait_done();
      chk({24'h0, starts - s0}, 32'h4, "four conversions");
      chk({30'h0, conv_channel}, 32'h3, "last channel");
      wr(C1, 32'h00008002);
      wr(C1, 32'h00008000);
      repeat (2) @(posedge hclk);
      chk({28'h0, sh_sample}, 32'hE, "one channel holds");
      wait_done();
      // automatic start with the internal counter, core answering promptly
      lat <= 8'h01;
      wr(C2, 32'h00000000);
      s0 = starts;
      wr(C1, 32'h000080E4);
      n = 0;
      while (8'(starts - s0) < 8'h03 && n < 400)
      begin
         @(posedge hclk);
         n++;
      end
      chk({24'h0, 8'(starts - s0) >= 8'h03}, 32'h1, "auto restart");
      wr(C1, 32'h00000000);
      give_verdict();
   end
endmodule // test_adc_sample_convert_control

`default_nettype wire
